//--- inc/byte_exec_map.svh
// constants of the byte instruction execute unit
`ifndef BYTE_EXEC_MAP_SVH
`define BYTE_EXEC_MAP_SVH
`define REG_ADDR_MAX       7'h7F
`define ACC_RESET          8'h00
`define FLAGS_RESET        3'h0
`define FLAG_CARRY_POS     0
`define FLAG_NIBBLE_POS    1
`define FLAG_ZERO_POS      2
`define DEST_ACC           1'h0
`define DEST_REG           1'h1
`define OFF_CTRL           32'h0000_0000
`define OFF_STATUS         32'h0000_0004
`define OFF_ACC            32'h0000_0008
`define CTRL_ENABLE_POS    0
`define CTRL_RESET         1'h1
`endif

//--- inc/byte_exec_pkg.sv
// types of the byte instruction execute unit
package byte_exec_pkg;
	typedef enum logic [3:0] {
		idle_op          = 4'h0,
		bit_clear_op     = 4'h1,
		bit_set_op       = 4'h2,
		add_acc_reg_op   = 4'h3,
		and_literal_op   = 4'h4,
		test_skip_if_zero_op = 4'h5,
		and_acc_reg_op   = 4'h6,
		reg_move_op      = 4'h7,
		acc_to_reg_op    = 4'h8,
		literal_load_op  = 4'h9
	} opcode_t;

	typedef struct packed {
		opcode_t    op;
		logic [6:0] addr;
		logic [2:0] bit_sel;
		logic       dest;
		logic [7:0] literal;
	} instr_t;

	typedef struct packed {
		logic zero;
		logic nibble_carry_flag;
		logic carry;
	} flags_t;

	typedef struct packed {
		logic       wr_en;
		logic [6:0] addr;
		logic [7:0] data;
	} file_wr_t;
endpackage

//--- logic/byte_alu.sv
// combinational arithmetic and logic core of the execute unit
`timescale 1ns/10ps
module byte_alu (
	input  wire byte_exec_pkg::opcode_t op,
	input  wire logic [7:0]             acc,
	input  wire logic [7:0]             operand,
	input  wire logic [2:0]             bit_sel,
	output logic [7:0]                  result,
	output logic                        carry,
	output logic                        nibble_carry,
	output logic                        bit_value
);
	wire [8:0] sum_full;
	wire [4:0] sum_low;
	wire [7:0] bit_mask;

	assign sum_full     = {1'b0, acc} + {1'b0, operand};
	assign sum_low      = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
	assign bit_mask     = 8'h01 << bit_sel;
	assign carry        = sum_full[8];
	assign nibble_carry = sum_low[4];
	assign bit_value    = |(operand & bit_mask);

	always_comb begin
		case (op)
			byte_exec_pkg::bit_clear_op:     result = operand & ~bit_mask;
			byte_exec_pkg::bit_set_op:       result = operand | bit_mask;
			byte_exec_pkg::add_acc_reg_op:   result = sum_full[7:0];
			byte_exec_pkg::and_literal_op,
			byte_exec_pkg::and_acc_reg_op:   result = acc & operand;
			byte_exec_pkg::reg_move_op:      result = operand;
			byte_exec_pkg::acc_to_reg_op:    result = acc;
			byte_exec_pkg::literal_load_op:  result = operand;
			default:                         result = acc;
		endcase
	end
endmodule

//--- logic/byte_instruction_execute_unit.sv
// execute stage with file register array and apb control registers
// Summary of operation
// [RULE1] bit clear zeroes chosen bit of file register, flags kept
// [RULE2] bit set forces chosen bit of file register to one, flags kept
// [RULE3] register add sums accumulator and register, sets carry, nibble carry, zero
// [RULE4] destination bit zero writes accumulator, one writes file register
// [RULE5] literal and with accumulator into accumulator, only zero flag changes
// [RULE6] register and with accumulator to destination, only zero flag changes
// [RULE7] test skip if zero discards next instruction as idle when bit clear
// [RULE8] register move copies register to destination, zero flag updated
// [RULE9] register moved onto itself still sets zero flag from value
// [RULE10] accumulator copied to file register in one cycle, no flags
// [RULE11] literal loaded into accumulator in one cycle, no flags
// [RULE12] idle changes nothing, one cycle
// [RULE13] zero flag set on all zero result, cleared otherwise
`timescale 1ns/10ps
`include "byte_exec_map.svh"
module byte_instruction_execute_unit #(
	parameter int FILE_DEPTH = 128
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire byte_exec_pkg::instr_t instr,
	input  wire logic                  instr_valid,
	output logic                       instr_ready,
	output logic                       skip_next,
	output byte_exec_pkg::flags_t      flags,
	output logic [7:0]                 acc,
	output byte_exec_pkg::file_wr_t    file_wr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr
);
	if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_bad_depth
		$error("FILE_DEPTH must be 1 to 128");
	end

	logic [7:0]            file_mem [FILE_DEPTH];
	logic [7:0]            acc_reg;
	logic [7:0]            acc_next;
	byte_exec_pkg::flags_t flags_reg;
	byte_exec_pkg::flags_t flags_next;
	logic                  skip_reg;
	logic                  skip_next_w;
	logic                  enable_reg;
	byte_exec_pkg::file_wr_t wr_reg;
	logic [31:0]           prdata_reg;

	wire [7:0] operand;
	wire [7:0] file_value;
	wire [7:0] result;
	wire       carry_w;
	wire       nibble_w;
	wire       bit_value;
	wire       exec;
	wire       fire;
	wire       is_literal;
	wire       to_reg;
	wire       to_acc;
	wire       sets_zero;
	wire       sets_add;
	wire       apb_access;
	wire       sel_ctrl;
	wire       sel_status;
	wire       sel_acc;
	wire       mapped;

	function automatic logic zero_of(input logic [7:0] v);
		zero_of = (v == 8'h00);
	endfunction

	assign file_value = (int'(instr.addr) < FILE_DEPTH) ? file_mem[instr.addr] : 8'h00;
	assign is_literal = (instr.op == byte_exec_pkg::and_literal_op) ||
	                    (instr.op == byte_exec_pkg::literal_load_op);
	assign operand    = is_literal ? instr.literal : file_value;
	assign instr_ready = enable_reg;
	assign fire       = instr_valid && enable_reg;
	// [RULE7] skipped slot runs as idle
	assign exec       = fire && !skip_reg;

	byte_alu u_alu (
		.op           (instr.op),
		.acc          (acc_reg),
		.operand      (operand),
		.bit_sel      (instr.bit_sel),
		.result       (result),
		.carry        (carry_w),
		.nibble_carry (nibble_w),
		.bit_value    (bit_value)
	);

	// [RULE4] destination select for add, and, move
	assign to_reg = exec && (
		(instr.op == byte_exec_pkg::bit_clear_op) ||
		(instr.op == byte_exec_pkg::bit_set_op) ||
		(instr.op == byte_exec_pkg::acc_to_reg_op) ||
		(((instr.op == byte_exec_pkg::add_acc_reg_op) ||
		  (instr.op == byte_exec_pkg::and_acc_reg_op) ||
		  (instr.op == byte_exec_pkg::reg_move_op)) && instr.dest == `DEST_REG));
	// [RULE5] [RULE6] [RULE8] accumulator destinations
	assign to_acc = exec && (
		(instr.op == byte_exec_pkg::and_literal_op) ||
		(instr.op == byte_exec_pkg::literal_load_op) ||
		(((instr.op == byte_exec_pkg::add_acc_reg_op) ||
		  (instr.op == byte_exec_pkg::and_acc_reg_op) ||
		  (instr.op == byte_exec_pkg::reg_move_op)) && instr.dest == `DEST_ACC));
	// [RULE9] zero flag also for move back into register
	assign sets_zero = exec && (
		(instr.op == byte_exec_pkg::add_acc_reg_op) ||
		(instr.op == byte_exec_pkg::and_acc_reg_op) ||
		(instr.op == byte_exec_pkg::and_literal_op) ||
		(instr.op == byte_exec_pkg::reg_move_op));
	assign sets_add = exec && (instr.op == byte_exec_pkg::add_acc_reg_op);

	// [RULE11] literal load to accumulator
	assign acc_next = to_acc ? result : acc_reg;

	always_comb begin
		flags_next = flags_reg;
		// [RULE3] carry and nibble carry on add
		if (sets_add) begin
			flags_next.carry             = carry_w;
			flags_next.nibble_carry_flag = nibble_w;
		end
		// [RULE13] zero from eight bit result
		if (sets_zero)
			flags_next.zero = zero_of(result);
	end

	// [RULE7] tested bit clear drops the next instruction
	assign skip_next_w = exec && (instr.op == byte_exec_pkg::test_skip_if_zero_op) && !bit_value;

	assign apb_access = psel && penable;
	assign sel_ctrl   = (paddr == `OFF_CTRL);
	assign sel_status = (paddr == `OFF_STATUS);
	assign sel_acc    = (paddr == `OFF_ACC);
	assign mapped     = sel_ctrl || sel_status || sel_acc;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			acc_reg   <= `ACC_RESET;
			flags_reg <= `FLAGS_RESET;
		end else begin
			acc_reg   <= acc_next;
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn)
			skip_reg <= 1'b0;
		else if (fire)
			skip_reg <= skip_next_w;
	end

	// [RULE1] [RULE2] [RULE10] single cycle file write-back
	always_ff @(posedge mclk) begin
		if (to_reg && int'(instr.addr) < FILE_DEPTH)
			file_mem[instr.addr] <= result;
	end

	always_ff @(posedge mclk) begin
		if (!resetn)
			wr_reg <= '0;
		else
			wr_reg <= '{wr_en: to_reg, addr: instr.addr, data: result};
	end

	always_ff @(posedge mclk) begin
		if (!resetn)
			enable_reg <= `CTRL_RESET;
		else if (apb_access && pwrite && sel_ctrl)
			enable_reg <= pwdata[`CTRL_ENABLE_POS];
	end

	always_ff @(posedge mclk) begin
		if (!resetn)
			prdata_reg <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			if (sel_ctrl)
				prdata_reg <= {31'h0, enable_reg};
			else if (sel_status)
				prdata_reg <= {28'h0, skip_reg, flags_reg};
			else if (sel_acc)
				prdata_reg <= {24'h0, acc_reg};
			else
				prdata_reg <= 32'h0000_0000;
		end
	end

	// [RULE12] idle leaves state untouched by decode above
	assign acc       = acc_reg;
	assign flags     = flags_reg;
	assign skip_next = skip_reg;
	assign file_wr   = wr_reg;
	assign prdata    = prdata_reg;
	assign pready    = 1'b1;
	assign pslverr   = apb_access && !mapped;
endmodule

//--- tb/byte_exec_asserts.sv
// port assertions of the byte execute unit
`timescale 1ns/10ps
module byte_exec_asserts (
	input wire logic                    mclk,
	input wire logic                    resetn,
	input wire byte_exec_pkg::instr_t   instr,
	input wire logic                    instr_valid,
	input wire logic                    instr_ready,
	input wire logic                    skip_next,
	input wire byte_exec_pkg::flags_t   flags,
	input wire logic [7:0]              acc,
	input wire byte_exec_pkg::file_wr_t file_wr
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_go(c);
		instr_valid && instr_ready && !skip_next && c;
	endsequence
	sequence s_wr(d);
		file_wr.wr_en && file_wr.addr == $past(instr.addr) && d;
	endsequence
	property p_clr;
		s_go(instr.op == byte_exec_pkg::bit_clear_op)
			|=> s_wr($stable(flags) && !file_wr.data[$past(instr.bit_sel)]);
	endproperty
	a_clr: assert property (p_clr) else $error("bit clear wrong");
	property p_add;
		s_go(instr.op == byte_exec_pkg::add_acc_reg_op && instr.dest)
			|=> s_wr($stable(acc) && ((file_wr.data == 8'h00) == flags.zero));
	endproperty
	a_add: assert property (p_add) else $error("add to register wrong");
	property p_dst;
		s_go(instr.op == byte_exec_pkg::add_acc_reg_op && !instr.dest) |=> !file_wr.wr_en;
	endproperty
	a_dst: assert property (p_dst) else $error("add wrote register");
	property p_andl;
		s_go(instr.op == byte_exec_pkg::and_literal_op) |=> acc == ($past(acc) & $past(instr.literal))
			&& flags.zero == (acc == 8'h00) && flags[1:0] == $past(flags[1:0]);
	endproperty
	a_andl: assert property (p_andl) else $error("literal and wrong");
	property p_self;
		s_go(instr.op == byte_exec_pkg::reg_move_op && instr.dest)
			|=> s_wr($stable(acc) && ((file_wr.data == 8'h00) == flags.zero));
	endproperty
	a_self: assert property (p_self) else $error("self move wrong");
	property p_a2r;
		s_go(instr.op == byte_exec_pkg::acc_to_reg_op)
			|=> s_wr($stable(flags) && file_wr.data == $past(acc));
	endproperty
	a_a2r: assert property (p_a2r) else $error("store wrong");
	property p_lit;
		s_go(instr.op == byte_exec_pkg::literal_load_op)
			|=> acc == $past(instr.literal) && $stable(flags);
	endproperty
	a_lit: assert property (p_lit) else $error("literal load wrong");
	property p_skp;
		skip_next && instr_valid && instr_ready |=> !skip_next && $stable(acc) && $stable(flags);
	endproperty
	a_skp: assert property (p_skp) else $error("skipped slot changed state");
endmodule
bind byte_instruction_execute_unit byte_exec_asserts chk_u (.mclk, .resetn, .instr,
	.instr_valid, .instr_ready, .skip_next, .flags, .acc, .file_wr);

//--- tb/fetch_model.sv
// instruction source in place of fetch and sequencing
`timescale 1ns/10ps
module fetch_model (
	input  wire logic                  mclk,
	input  wire logic                  go,
	input  wire byte_exec_pkg::instr_t nxt,
	input  wire logic                  instr_ready,
	output byte_exec_pkg::instr_t      instr,
	output logic                       instr_valid
);
	initial begin
		instr = '0;
		instr_valid = 1'h0;
	end
	// offer held until taken, bus scrambled when idle
	always @(posedge mclk) begin
		if (!instr_valid || instr_ready) begin
			instr_valid <= go;
			instr <= go ? nxt : ~instr;
		end
	end
endmodule

//--- tb/byte_instruction_execute_unit_tb.sv
// self-checking bench of the byte execute unit
`timescale 1ns/10ps
`include "byte_exec_map.svh"
module byte_instruction_execute_unit_tb;
	logic mclk = 1'h0, resetn = 1'h0, go = 1'h0, tk = 1'h0, skp = 1'h0, w, pready, pslverr;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, instr_valid, instr_ready, skip_next;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rs = 32'hA33C;
	logic [7:0] a = 8'h00, acc, r, f, m [128];
	logic [2:0] fl = 3'h0;
	logic [32:0] eq [$];
	logic [14:0] wq [$];
	int n_fail = 0, n_checks = 0;
	byte_exec_pkg::instr_t nxt = '0, instr;
	byte_exec_pkg::flags_t flags;
	byte_exec_pkg::file_wr_t file_wr;
	always #50 mclk = ~mclk;
	fetch_model src_u (.mclk, .go, .nxt, .instr_ready, .instr, .instr_valid);
	byte_instruction_execute_unit dut_u (.mclk, .resetn, .instr, .instr_valid, .instr_ready,
		.skip_next, .flags, .acc, .file_wr, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [32:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [31:0] ad, d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [31:0] ad, input logic [32:0] e);
		eq.push_back(e);
		apb(1'h0, ad, 32'h0);
	endtask
	task automatic idle(input int n);
		go <= 1'h0;
		repeat (n) @(posedge mclk);
	endtask
	task automatic issue(input byte_exec_pkg::opcode_t o, input logic [6:0] ad,
		input logic [2:0] b, input logic d, input logic [7:0] l);
		logic [8:0] s;
		logic [4:0] h;
		f = m[ad];
		r = f;
		w = 1'h0;
		s = a + f;
		h = a[3:0] + f[3:0];
		if (skp)
			skp = 1'h0;
		else begin
			case (o)
			byte_exec_pkg::bit_clear_op: r[b] = 1'h0;
			byte_exec_pkg::bit_set_op: r[b] = 1'h1;
			byte_exec_pkg::add_acc_reg_op: r = s[7:0];
			byte_exec_pkg::and_acc_reg_op: r = a & f;
			byte_exec_pkg::and_literal_op: r = a & l;
			byte_exec_pkg::acc_to_reg_op: r = a;
			byte_exec_pkg::literal_load_op: r = l;
			byte_exec_pkg::test_skip_if_zero_op: skp = !f[b];
			default: ;
			endcase
			if (o == byte_exec_pkg::add_acc_reg_op)
				fl[1:0] = {h[4], s[8]};
			if (o == byte_exec_pkg::and_literal_op || o == byte_exec_pkg::literal_load_op)
				a = r;
			if (o inside {byte_exec_pkg::add_acc_reg_op, byte_exec_pkg::and_acc_reg_op,
				byte_exec_pkg::reg_move_op, byte_exec_pkg::and_literal_op}) begin
				fl[2] = r == 8'h00;
				w = d && o != byte_exec_pkg::and_literal_op;
				if (!d)
					a = r;
			end
			if (o inside {byte_exec_pkg::bit_clear_op, byte_exec_pkg::bit_set_op,
				byte_exec_pkg::acc_to_reg_op})
				w = 1'h1;
		end
		if (w) begin
			m[ad] = r;
			wq.push_back({ad, r});
		end
		eq.push_back({22'h0, fl, a});
		nxt <= '{o, ad, b, d, l};
		go <= 1'h1;
		@(posedge mclk);
	endtask
	always @(posedge mclk) begin
		if (tk)
			chk({22'h0, flags, acc}, eq.pop_front());
		if (file_wr.wr_en === 1'h1)
			chk({17'h0, file_wr}, {18'h1, wq.pop_front()});
		if (psel && penable && !pwrite && pready === 1'h1)
			chk({pslverr, prdata}, eq.pop_front());
		tk <= instr_valid && instr_ready && resetn;
	end
	initial begin
		byte_exec_pkg::instr_t i;
		repeat (8) @(posedge mclk);
		resetn <= 1'h1;
		rd(`OFF_STATUS, 33'h0);
		for (int k = 0; k < 128; k++) begin
			issue(byte_exec_pkg::literal_load_op, 7'h00, 3'h0, 1'h0, 8'(k * 37));
			issue(byte_exec_pkg::acc_to_reg_op, 7'(k), 3'h0, 1'h0, 8'h00);
		end
		for (int k = 0; k < 600; k++) begin
			rs = lfsr(rs);
			i = rs[22:0];
			if (rs[30])
				issue(byte_exec_pkg::opcode_t'(rs[3:0] % 4'hA), i.addr, i.bit_sel, i.dest, i.literal);
			else
				idle(1);
		end
		idle(5);
		rd(`OFF_STATUS, {29'h0, skp, fl});
		rd(`OFF_ACC, {25'h0, a});
		rd(32'h0000_000C, {1'h1, 32'h0});
		apb(1'h1, `OFF_CTRL, 32'h0);
		rd(`OFF_CTRL, 33'h0);
		wrap_up;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		n_fail++;
		wrap_up;
	end
endmodule
